// ### rtl/ehba_defs.svh
// constant definitions for the external bus hold arbiter
`ifndef EHBA_DEFS_SVH
`define EHBA_DEFS_SVH
`define EHBA_NREQ        5
`define EHBA_IDX_HOLD    0
`define EHBA_IDX_DMA     1
`define EHBA_IDX_OPND    2
`define EHBA_IDX_BRF     3
`define EHBA_IDX_SEQF    4
`define EHBA_ST_IDLE     5'h01
`define EHBA_ST_CYCLE    5'h02
`define EHBA_ST_LOCKGAP  5'h04
`define EHBA_ST_HOLD     5'h08
`define EHBA_ST_SLEEP    5'h10
`define EHBA_SYNC_IDLE   2'h3
`endif

// ### rtl/ehba_pkg.sv
// types for the external bus hold arbiter
`include "ehba_defs.svh"
package ehba_pkg;
    // arbiter states, one-hot
    typedef enum logic [4:0] {
        EHBA_IDLE    = `EHBA_ST_IDLE,
        EHBA_CYCLE   = `EHBA_ST_CYCLE,
        EHBA_LOCKGAP = `EHBA_ST_LOCKGAP,
        EHBA_HOLD    = `EHBA_ST_HOLD,
        EHBA_SLEEP   = `EHBA_ST_SLEEP
    } ehba_state_t;

    // power mode inputs
    typedef struct packed {
        logic stop_mode;
        logic light_sleep_mode_one;
        logic light_sleep_mode_two;
        logic halt_mode;
    } ehba_pwr_t;

    // internal bus requests; lock_next marks that another access of the same sequence follows
    typedef struct packed {
        logic dma_req;
        logic opnd_req;
        logic opnd_lock_next;
        logic opnd_rmw_read;
        logic brf_req;
        logic seqf_req;
        logic cycle_done;
    } ehba_req_t;

    // grants to internal masters
    typedef struct packed {
        logic dma_gnt;
        logic opnd_gnt;
        logic brf_gnt;
        logic seqf_gnt;
    } ehba_gnt_t;

    // whole state of the arbiter
    typedef struct packed {
        ehba_state_t state;
        logic [1:0]  rq_sync;
        logic        grant_n;
        logic        bus_oe;
        ehba_gnt_t   gnt;
        logic        lock;
        logic        rmw;
        logic        stall;
    } ehba_regs_t;
endpackage : ehba_pkg

// ### rtl/ehba_arbiter.sv
// external bus hold arbiter with fixed priority and lock handling
// How it works
// - hold pins act only in alternate function
// - request low floats address and data bus
// - request high resumes driving the bus
// - internal memory execution continues during hold
// - grant low for whole hold state
// - no hold inside multiple-access sequence
// - 16-bit bus sizing sequences stay unbroken
// - 8-bit bus splits locked, no hold
// - no hold between bit-op read, write
// - no hold entered in stop or sleep modes
// - halt mode enters, leaves hold directly
// - priority: hold, dma, operand, branch, sequential
// - fetch allowed between read and write
// - sizing split blocks fetch and hold
`timescale 1ns/1ps
`default_nettype none
`include "ehba_defs.svh"
module ehba_arbiter
    import ehba_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      nrst,
    input  wire logic      clk_en,
    input  wire logic      bus_hold_request_n,
    input  wire logic      port_cm_bit_two,
    input  wire logic      port_cm_bit_three,
    input  wire ehba_pwr_t pwr,
    input  wire ehba_req_t req,
    input  wire logic      cpu_ext_access,
    output logic           bus_hold_grant_n,
    output logic           bus_hold_grant_oe,
    output logic           ext_bus_oe,
    output ehba_gnt_t      gnt,
    output logic           cpu_stall
);
    ehba_regs_t r_q;      // registered state
    ehba_regs_t r_d;      // next state
    logic       hold_req; // qualified, synchronised request
    logic       pins_alt; // both pins in alternate function
    logic       asleep;   // system clock stopped
    logic       any_int;  // some internal master wants bus

    // qualifiers read by the state machine
    // the raw pin is never read here, only the second sync flop,
    // so a metastable first stage cannot reach the decode
    always_comb begin
        pins_alt = port_cm_bit_two & port_cm_bit_three;
        asleep   = pwr.stop_mode | pwr.light_sleep_mode_one | pwr.light_sleep_mode_two;
        hold_req = pins_alt & ~r_q.rq_sync[1];
        any_int  = req.dma_req | req.opnd_req | req.brf_req | req.seqf_req;
    end

    // next-state logic for the whole arbiter
    // one pass builds the whole next state; the register below
    // takes it only while clk_en is high
    always_comb begin
        r_d = r_q;
        r_d.rq_sync = {r_q.rq_sync[0], bus_hold_request_n};
        r_d.gnt     = '0;
        case (r_q.state)
            EHBA_IDLE: begin
                // hold is checked before any internal master
                if (asleep) begin
                    r_d.state = EHBA_SLEEP;
                end else if (hold_req) begin
                    r_d.state = EHBA_HOLD;
                end else if (any_int) begin
                    r_d.state = EHBA_CYCLE;
                    if (req.dma_req) begin
                        r_d.gnt.dma_gnt = 1'b1;
                    end else if (req.opnd_req) begin
                        r_d.gnt.opnd_gnt = 1'b1;
                        r_d.lock = req.opnd_lock_next;
                        r_d.rmw  = req.opnd_rmw_read;
                    end else if (req.brf_req) begin
                        r_d.gnt.brf_gnt = 1'b1;
                    end else begin
                        r_d.gnt.seqf_gnt = 1'b1;
                    end
                end
            end
            EHBA_CYCLE: begin
                // a hold seen now waits; the access in flight finishes first
                r_d.gnt = r_q.gnt; // grant stands until cycle ends
                if (req.cycle_done) begin
                    r_d.gnt = '0;
                    r_d.state = (r_q.lock | r_q.rmw) ? EHBA_LOCKGAP : EHBA_IDLE;
                end
            end
            EHBA_LOCKGAP: begin
                // in a split only the operand continues, in a bit-op gap fetch may too; hold waits
                // a dropped locked request parks the bus here; the cpu
                // always completes its split, so this costs nothing in use
                if (r_q.lock) begin
                    if (req.opnd_req) begin
                        r_d.state        = EHBA_CYCLE;
                        r_d.gnt.opnd_gnt = 1'b1;
                        r_d.lock         = req.opnd_lock_next;
                        r_d.rmw          = req.opnd_rmw_read & r_q.rmw;
                    end
                end else if (req.opnd_req) begin
                    r_d.state        = EHBA_CYCLE;
                    r_d.gnt.opnd_gnt = 1'b1;
                    r_d.rmw          = 1'b0;
                    r_d.lock         = req.opnd_lock_next;
                end else if (req.brf_req | req.seqf_req) begin
                    r_d.state = EHBA_CYCLE;
                    r_d.gnt.brf_gnt  = req.brf_req;
                    r_d.gnt.seqf_gnt = ~req.brf_req;
                end
            end
            EHBA_HOLD: begin
                // internal grants stay cleared; masters wait at their requests
                // halt or run: leave when request drops
                if (~hold_req) begin
                    r_d.state = EHBA_IDLE;
                end
            end
            EHBA_SLEEP: begin
                // clock stopped: nothing is granted, a pending hold waits
                if (~asleep) begin
                    r_d.state = EHBA_IDLE;
                end
            end
            default: r_d.state = EHBA_IDLE;
        endcase
        r_d.bus_oe  = (r_d.state != EHBA_HOLD);
        r_d.grant_n = ~(r_d.state == EHBA_HOLD);
        // stall only for external or peripheral
        r_d.stall   = (r_d.state == EHBA_HOLD) & cpu_ext_access;
    end

    // state register, frozen while clock enable low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // reset leaves the bus driven and the grant pin released
            r_q         <= '0;
            r_q.state   <= EHBA_IDLE;
            r_q.rq_sync <= `EHBA_SYNC_IDLE;
            r_q.grant_n <= 1'h1;
            r_q.bus_oe  <= 1'h1;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    // pins only driven in alternate function
    // separate flop so the pin enable follows the port mode setting
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_hold_grant_oe <= 1'b0;
        end else if (clk_en) begin
            bus_hold_grant_oe <= pins_alt;
        end
    end

    // outputs are plain copies of flops, no decode in between,
    // which keeps pin timing independent of the request logic
    always_comb begin
        bus_hold_grant_n = r_q.grant_n;
        ext_bus_oe       = r_q.bus_oe;
        gnt              = r_q.gnt;
        cpu_stall        = r_q.stall;
    end

    // all checks below run on the system clock and sleep through reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    hold_floats_bus_a: assert property (!bus_hold_grant_n |-> !ext_bus_oe)
        else $error("bus driven while hold granted");

    release_drives_a: assert property (
        clk_en && r_q.state == EHBA_HOLD && !hold_req |=> ext_bus_oe && bus_hold_grant_n)
        else $error("bus not resumed after release");

    resume_oe_a: assert property (bus_hold_grant_n |-> ext_bus_oe)
        else $error("bus floating outside hold");

    grant_in_hold_a: assert property (bus_hold_grant_n == (r_q.state != EHBA_HOLD))
        else $error("grant does not match hold");

    no_hold_lock_a: assert property (r_q.state == EHBA_LOCKGAP |=> r_q.state != EHBA_HOLD)
        else $error("hold inside locked sequence");

    lock_next_a: assert property (
        clk_en && r_q.state == EHBA_LOCKGAP && r_q.lock && req.opnd_req |=> gnt.opnd_gnt)
        else $error("locked access not continued");

    gap_no_dma_a: assert property (
        clk_en && r_q.state == EHBA_LOCKGAP && r_q.lock |=> !gnt.dma_gnt)
        else $error("dma inside sized split");

    no_fetch_split_a: assert property (
        clk_en && r_q.state == EHBA_LOCKGAP && r_q.lock |=> !gnt.brf_gnt && !gnt.seqf_gnt)
        else $error("fetch inside sized split");

    rmw_write_a: assert property (
        clk_en && r_q.state == EHBA_LOCKGAP && !r_q.lock && req.opnd_req |=> gnt.opnd_gnt)
        else $error("bit-op write not served");

    rmw_fetch_a: assert property (
        clk_en && r_q.state == EHBA_LOCKGAP && !r_q.lock && !req.opnd_req && req.brf_req
        |=> gnt.brf_gnt)
        else $error("fetch refused in bit-op gap");

    sleep_no_hold_a: assert property (
        clk_en && asleep && r_q.state != EHBA_HOLD |=> r_q.state != EHBA_HOLD)
        else $error("hold entered while asleep");

    halt_hold_a: assert property (
        clk_en && pwr.halt_mode && !asleep && r_q.state == EHBA_IDLE && hold_req
        |=> !bus_hold_grant_n)
        else $error("hold refused in halt");

    dma_first_a: assert property (
        clk_en && r_q.state == EHBA_IDLE && !asleep && !hold_req && req.dma_req |=> gnt.dma_gnt)
        else $error("dma not granted first");

    opnd_next_a: assert property (
        clk_en && r_q.state == EHBA_IDLE && !asleep && !hold_req && !req.dma_req
        && req.opnd_req |=> gnt.opnd_gnt)
        else $error("operand not ahead of fetch");

    brf_next_a: assert property (
        clk_en && r_q.state == EHBA_IDLE && !asleep && !hold_req && !req.dma_req
        && !req.opnd_req && req.brf_req |=> gnt.brf_gnt)
        else $error("branch fetch not ahead");

    gnt_onehot_a: assert property ($onehot0(gnt))
        else $error("two internal grants at once");

    no_gnt_hold_a: assert property (!bus_hold_grant_n |-> gnt == '0)
        else $error("internal grant during hold");

    sync_delay_a: assert property (
        clk_en && r_q.state == EHBA_IDLE && !asleep && hold_req |=> !bus_hold_grant_n)
        else $error("hold not entered from idle");

    no_sync_grant_a: assert property (
        clk_en && r_q.state != EHBA_HOLD && !hold_req |=> bus_hold_grant_n)
        else $error("hold granted without request");

    cycle_first_a: assert property (r_q.state == EHBA_CYCLE |=> r_q.state != EHBA_HOLD)
        else $error("hold cut a bus cycle");

    // grant stands until cycle ends
    grant_stands_a: assert property (
        clk_en && r_q.state == EHBA_CYCLE && !req.cycle_done |=> $stable(gnt))
        else $error("grant dropped inside cycle");

    // clock enable freezes all state
    freeze_a: assert property (
        !clk_en |=> $stable(r_q) && $stable(bus_hold_grant_oe))
        else $error("state moved while frozen");

    alt_only_a: assert property (!pins_alt && clk_en |=> !bus_hold_grant_oe)
        else $error("grant pin driven without alternate");

    stall_cause_a: assert property (cpu_stall |-> !bus_hold_grant_n)
        else $error("cpu stalled outside hold");

    // main scenarios: hold round trip, split, fetch in rmw, sleep, halt
    hold_seen_c: cover property (!bus_hold_grant_n ##1 bus_hold_grant_n);
    lock_seen_c: cover property (r_q.state == EHBA_LOCKGAP ##1 gnt.opnd_gnt);
    rmw_fetch_c: cover property (r_q.state == EHBA_LOCKGAP && !r_q.lock ##1 gnt.brf_gnt);
    sleep_c:     cover property (r_q.state == EHBA_SLEEP);
    halt_hold_c: cover property (pwr.halt_mode && !bus_hold_grant_n);
endmodule : ehba_arbiter
`default_nettype wire

// ### tb/ehba_ext_master.sv
// model of the outside bus master sharing the address and data bus
`timescale 1ns/1ps
`default_nettype none
module ehba_ext_master (
    input  wire logic sys_clk,
    input  wire logic want,
    input  wire logic bus_hold_grant_n,
    output logic      bus_hold_request_n,
    output logic      drive
);
    // idle master: request high, bus not driven
    initial begin
        bus_hold_request_n = 1'h1;
        drive = 1'h0;
    end
    always @(posedge sys_clk) begin
        #1;
        if (want) begin
            bus_hold_request_n = 1'h0;
            drive = !bus_hold_grant_n;
        end else if (drive) begin
            // let go of the pins a cycle before the request
            drive = 1'h0;
        end else begin
            bus_hold_request_n = 1'h1;
        end
    end
endmodule : ehba_ext_master
`default_nettype wire

// ### tb/test_ehba_arbiter.sv
// self-checking bench for the external bus hold arbiter
`timescale 1ns/1ps
`default_nettype none
module test_ehba_arbiter;
    import ehba_pkg::*;
    logic      sys_clk = 0, nrst = 0, want = 0, cpu_ext_access = 0, clk_en = 1;
    logic      port_cm_bit_two = 1, port_cm_bit_three = 1;
    ehba_pwr_t pwr = '0;
    ehba_req_t req = '0;
    ehba_gnt_t gnt;
    logic      grant_n, grant_oe, ext_bus_oe, cpu_stall, req_n, drive;
    int        fail_count = 0, n_checks = 0;
    // clk_en low is exercised by the freeze scenario
    ehba_arbiter ehba_arbiter_i (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .bus_hold_request_n(req_n), .port_cm_bit_two(port_cm_bit_two),
        .port_cm_bit_three(port_cm_bit_three), .pwr(pwr), .req(req),
        .cpu_ext_access(cpu_ext_access), .bus_hold_grant_n(grant_n),
        .bus_hold_grant_oe(grant_oe), .ext_bus_oe(ext_bus_oe), .gnt(gnt),
        .cpu_stall(cpu_stall));
    ehba_ext_master ehba_ext_master_i (.sys_clk(sys_clk), .want(want),
        .bus_hold_grant_n(grant_n), .bus_hold_request_n(req_n), .drive(drive));
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // inputs always move 1 ns after the edge
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    // bounded waits: synchroniser plus a cycle in flight
    task hold_wait(input logic v);
        for (int i = 0; i < 10 && grant_n !== v; i++) cyc(1);
        chk(grant_n, v);
    endtask : hold_wait
    task gnt_wait(input logic [3:0] e);
        for (int i = 0; i < 12 && gnt === 4'h0; i++) cyc(1);
        chk(gnt, e);
    endtask : gnt_wait
    task done_pulse;
        req.cycle_done = 1;
        cyc(1);
        req.cycle_done = 0;
    endtask : done_pulse
    task stop_test;
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // plain hold, hold above dma, stall on external need
    task t_hold;
        want = 1;
        hold_wait(0);
        chk(ext_bus_oe, 0);
        chk(grant_oe, 1);
        req.dma_req = 1;
        cpu_ext_access = 1;
        cyc(3);
        chk(gnt, 0);
        chk(cpu_stall, 1);
        chk(drive, 1);
        cpu_ext_access = 0;
        cyc(2);
        chk(cpu_stall, 0);
        want = 0;
        hold_wait(1);
        chk(ext_bus_oe, 1);
        chk(drive, 0);
        gnt_wait(4'h8);
        done_pulse;
        req.dma_req = 0;
    endtask : t_hold
    // clock enable low freezes the hold across a release
    task t_freeze;
        want = 1;
        hold_wait(0);
        clk_en = 0;
        want = 0;
        cyc(8);
        chk(grant_n, 0);
        chk(ext_bus_oe, 0);
        clk_en = 1;
        hold_wait(1);
        chk(ext_bus_oe, 1);
    endtask : t_freeze
    // pins in port mode ignore the request
    task t_pins;
        port_cm_bit_three = 0;
        want = 1;
        cyc(6);
        chk(grant_n, 1);
        chk(grant_oe, 0);
        want = 0;
        cyc(3);
        port_cm_bit_three = 1;
        cyc(2);
    endtask : t_pins
    // all four requesters at once, served in order
    task t_prio;
        logic [3:0] m;
        m = 4'hF;
        for (int k = 0; k < 4; k++) begin
            {req.dma_req, req.opnd_req, req.brf_req, req.seqf_req} = m;
            gnt_wait(4'h8 >> k);
            done_pulse;
            m = m >> 1;
        end
        {req.dma_req, req.opnd_req, req.brf_req, req.seqf_req} = 4'h0;
    endtask : t_prio
    // four-access split with hold and fetch pending
    task t_lock;
        req.opnd_req = 1;
        req.brf_req = 1;
        for (int k = 0; k < 4; k++) begin
            req.opnd_lock_next = (k < 3);
            gnt_wait(4'h4);
            if (k == 0) want = 1;
            cyc(3);
            chk(grant_n, 1);
            done_pulse;
        end
        req.opnd_req = 0;
        hold_wait(0);
        want = 0;
        hold_wait(1);
        gnt_wait(4'h2);
        done_pulse;
        req.brf_req = 0;
    endtask : t_lock
    // bit-op read, fetch in the gap, no hold there
    task t_rmw;
        req.opnd_req = 1;
        req.opnd_rmw_read = 1;
        gnt_wait(4'h4);
        want = 1;
        req.brf_req = 1;
        cyc(3);
        done_pulse;
        req.opnd_req = 0;
        req.opnd_rmw_read = 0;
        gnt_wait(4'h2);
        chk(grant_n, 1);
        done_pulse;
        req.brf_req = 0;
        req.opnd_req = 1;
        want = 0;
        gnt_wait(4'h4);
        done_pulse;
        req.opnd_req = 0;
        cyc(6);
    endtask : t_rmw
    // stop and both sleeps refuse, halt behaves as run
    task t_sleep;
        for (int i = 0; i < 3; i++) begin
            pwr = ehba_pwr_t'(4'h8 >> i);
            want = 1;
            cyc(6);
            chk(grant_n, 1);
            want = 0;
            cyc(4);
        end
        pwr = ehba_pwr_t'(4'h1);
        want = 1;
        hold_wait(0);
        want = 0;
        hold_wait(1);
        pwr = '0;
    endtask : t_sleep
    // reset for 20 cycles, then the scenarios
    initial begin
        cyc(20);
        nrst = 1;
        cyc(2);
        t_hold;
        t_freeze;
        t_pins;
        t_prio;
        t_lock;
        t_rmw;
        t_sleep;
        stop_test;
    end
    // watchdog well past the few hundred cycles needed
    initial begin
        #50000;
        fail_count++;
        stop_test;
    end
endmodule : test_ehba_arbiter
`default_nettype wire
